// File: hdl/dscp_device.sv
// Converter end of the control port: three-wire write port and two-wire slave.
// Assumes the register file sits on clk_i and answers rd_data_i for rd_addr_o.
`timescale 1ns/100ps
`default_nettype none
module dscp_device
  import dscp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  dscp_link_if.dev_mp link,
  output logic wr_o,
  output logic [6:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [6:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic spi_mode_o,
  output logic mode_valid_o
);
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK, I_TXLD} dscp_i2c_e;
  typedef enum logic [1:0] {K_SLA, K_REG, K_DAT} dscp_kind_e;

  // ---------------- Three-wire link domain ----------------
  logic [14:0] ssh_reg;
  logic [4:0] scnt_reg;
  logic sfirst_reg;
  logic [3:0] sext_reg;
  logic [6:0] hold_addr_reg;
  logic [7:0] hold_data_reg;
  logic hold_wr_reg;
  logic tog_reg;

  // Select high holds the frame counters in reset, so a frame ends with its select.
  wire spi_arst = sys_rst_i | link.ctl_port_select;
  wire unit_done = scnt_reg == (sfirst_reg ? SPI_FIRST_LAST : SPI_BYTE_LAST);
  wire unit_take = unit_done & (sfirst_reg | (sext_reg != SPI_MAX_EXTRA));

  always_ff @(posedge link.ctl_bit_clock or posedge spi_arst) begin
    if (spi_arst) begin
      ssh_reg <= 15'h0000;
      scnt_reg <= 5'h00;
      sfirst_reg <= 1'b1;
      sext_reg <= 4'h0;
    end else begin
      ssh_reg <= {ssh_reg[13:0], link.ctl_serial_data_in};
      if (unit_done) begin
        scnt_reg <= 5'h00;
        sfirst_reg <= 1'b0;
        if (unit_take && !sfirst_reg) begin
          sext_reg <= sext_reg + 4'h1;
        end
      end else begin
        scnt_reg <= scnt_reg + 5'h01;
      end
    end
  end

  // Completed units, up to SPI_MAX_EXTRA after the first in a frame, are held here and announced by a toggle; they stay stable
  // for at least eight bit clocks, long enough for the system side to copy them.
  always_ff @(posedge link.ctl_bit_clock or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_addr_reg <= 7'h00;
      hold_data_reg <= 8'h00;
      hold_wr_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else if (unit_take) begin
      hold_data_reg <= {ssh_reg[6:0], link.ctl_serial_data_in};
      hold_addr_reg <= sfirst_reg ? ssh_reg[13:7] : hold_addr_reg + 7'h01;
      hold_wr_reg <= sfirst_reg ? ~ssh_reg[14] : hold_wr_reg;
      tog_reg <= ~tog_reg;
    end
  end

  // ---------------- System clock domain ----------------
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] tog_s_reg;
  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic [1:0] settle_reg;
  logic pend_v_reg;
  logic pend_wr_reg;
  logic [6:0] pend_addr_reg;
  logic [7:0] pend_data_reg;
  dscp_i2c_e st_reg;
  dscp_kind_e kind_reg;
  logic [2:0] cnt_reg;
  logic [7:0] sh_reg;
  logic ack_drv_reg;
  logic ack_go_reg;
  logic rw_reg;
  logic [6:0] idx_reg;
  logic oe_reg;

  // Element 0 of each chain is the first synchroniser stage, read only by element 1.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      tog_s_reg <= 3'h0;
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
    end else begin
      pin_s1_reg <= {link.mode_sel, link.bus_addr_sel_hi, link.ctl_port_select};
      pin_s2_reg <= pin_s1_reg;
      tog_s_reg <= {tog_s_reg[1:0], tog_reg};
      scl_s_reg <= {scl_s_reg[1:0], link.ctl_bit_clock};
      sda_s_reg <= {sda_s_reg[1:0], link.ctl_serial_data_in};
    end
  end

  wire mode_pin = pin_s2_reg[2];
  wire adr_hi = pin_s2_reg[1];
  wire adr_lo = pin_s2_reg[0];
  wire sel_hi = pin_s2_reg[0];

  // The strap is caught a few cycles after release, once the synchroniser holds it.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settle_reg <= 2'h0;
      mode_valid_o <= 1'b0;
      spi_mode_o <= 1'b0;
    end else if (!mode_valid_o) begin
      if (settle_reg == MODE_SETTLE) begin
        spi_mode_o <= mode_pin;
        mode_valid_o <= 1'b1;
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  wire spi_on = mode_valid_o & spi_mode_o;
  wire i2c_on = mode_valid_o & ~spi_mode_o;

  // Three-wire commit: a unit waits until the next unit arrives or select is high.
  wire tog_ev = tog_s_reg[1] ^ tog_s_reg[2];
  wire spi_commit = spi_on & pend_v_reg & (tog_ev | sel_hi);
  wire spi_wr = spi_commit & pend_wr_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_v_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      pend_addr_reg <= 7'h00;
      pend_data_reg <= 8'h00;
    end else if (tog_ev && spi_on) begin
      pend_v_reg <= 1'b1;
      pend_wr_reg <= hold_wr_reg;
      pend_addr_reg <= hold_addr_reg;
      pend_data_reg <= hold_data_reg;
    end else if (spi_commit) begin
      pend_v_reg <= 1'b0;
    end
  end

  // ---------------- Two-wire slave ----------------
  wire scl_rise = scl_s_reg[1] & ~scl_s_reg[2];
  wire scl_fall = ~scl_s_reg[1] & scl_s_reg[2];
  wire scl_high = scl_s_reg[1] & scl_s_reg[2];
  wire sda_in = sda_s_reg[1];
  wire bus_start = scl_high & sda_s_reg[2] & ~sda_in;
  wire bus_stop = scl_high & ~sda_s_reg[2] & sda_in;
  wire [7:0] byte_nb = {sh_reg[6:0], sda_in};
  wire sla_hit = byte_nb[7:1] == {SLA_FIXED, adr_hi, adr_lo};
  wire reg_ok = ~byte_nb[7] & (byte_nb[6:0] >= REG_FIRST) & (byte_nb[6:0] <= REG_LAST);
  wire [6:0] idx_inc = (idx_reg == REG_LAST) ? REG_FIRST : idx_reg + 7'h01;
  wire rx_done = (st_reg == I_RX) & scl_rise & (cnt_reg == BYTE_LAST);
  wire i2c_wr = rx_done & (kind_reg == K_DAT);
  wire ack_sel = (kind_reg == K_SLA) ? sla_hit : ((kind_reg == K_REG) ? reg_ok : 1'b1);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= I_IDLE;
      kind_reg <= K_SLA;
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      ack_drv_reg <= 1'b0;
      ack_go_reg <= 1'b0;
      rw_reg <= 1'b0;
      idx_reg <= REG_FIRST;
      oe_reg <= 1'b0;
    end else if (!i2c_on || bus_stop) begin
      st_reg <= I_IDLE;
      oe_reg <= 1'b0;
    end else if (bus_start) begin
      // A repeated start lands here too and re-reads the slave address.
      st_reg <= I_RX;
      kind_reg <= K_SLA;
      cnt_reg <= 3'h0;
      oe_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        I_IDLE: begin
        end
        I_RX: begin
          if (scl_rise) begin
            sh_reg <= byte_nb;
            cnt_reg <= cnt_reg + 3'h1;
            if (rx_done) begin
              st_reg <= I_ACK;
              ack_drv_reg <= 1'b0;
              ack_go_reg <= ack_sel;
              if (kind_reg == K_SLA) begin
                rw_reg <= sda_in;
              end
              if (kind_reg == K_REG && reg_ok) begin
                idx_reg <= byte_nb[6:0];
              end
              if (kind_reg == K_DAT) begin
                idx_reg <= idx_inc;
              end
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            if (!ack_drv_reg) begin
              ack_drv_reg <= 1'b1;
              oe_reg <= ack_go_reg;
            end else if (!ack_go_reg) begin
              st_reg <= I_IDLE;
              oe_reg <= 1'b0;
            end else if (kind_reg == K_SLA && rw_reg) begin
              st_reg <= I_TX;
              sh_reg <= rd_data_i;
              oe_reg <= ~rd_data_i[7];
              cnt_reg <= 3'h0;
            end else begin
              st_reg <= I_RX;
              oe_reg <= 1'b0;
              cnt_reg <= 3'h0;
              kind_reg <= (kind_reg == K_SLA) ? K_REG : K_DAT;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            if (cnt_reg == BYTE_LAST) begin
              st_reg <= I_TXACK;
              oe_reg <= 1'b0;
            end else begin
              oe_reg <= ~sh_reg[6];
              sh_reg <= {sh_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 3'h1;
            end
          end
        end
        I_TXACK: begin
          if (scl_rise) begin
            if (sda_in) begin
              st_reg <= I_IDLE;
            end else begin
              idx_reg <= idx_inc;
              st_reg <= I_TXLD;
            end
          end
        end
        I_TXLD: begin
          if (scl_fall) begin
            st_reg <= I_TX;
            sh_reg <= rd_data_i;
            oe_reg <= ~rd_data_i[7];
            cnt_reg <= 3'h0;
          end
        end
      endcase
    end
  end

  // ---------------- Outputs ----------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_o <= 1'b0;
      wr_addr_o <= 7'h00;
      wr_data_o <= 8'h00;
      rd_addr_o <= REG_FIRST;
      link.dev_dat_o <= 1'b0;
      link.dev_dat_oe <= 1'b0;
    end else begin
      wr_o <= spi_wr | i2c_wr;
      wr_addr_o <= spi_on ? pend_addr_reg : idx_reg;
      wr_data_o <= spi_on ? pend_data_reg : byte_nb;
      rd_addr_o <= idx_reg;
      link.dev_dat_o <= 1'b0;
      link.dev_dat_oe <= oe_reg;
    end
  end
endmodule : dscp_device
`default_nettype wire

// File: hdl/dscp_host.sv
// Host end of the control port: master for the three-wire and two-wire links.
// Assumes spi_mode_i matches the strap the converter caught at its reset.
`timescale 1ns/100ps
`default_nettype none
module dscp_host
  import dscp_pkg::*;
#(
  parameter logic [7:0] SPI_PH = 8'(SPI_PH_CYC),
  parameter logic [7:0] I2C_PH = 8'(I2C_PH_CYC)
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  dscp_link_if.host_mp link,
  input wire logic spi_mode_i,
  input wire logic [1:0] addr_sel_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_read_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [3:0] cmd_len_i,
  input wire logic [7:0] cmd_data_i,
  output logic data_take_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rd_data_o
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_SELLO, H_SELHI} dscp_hst_e;
  typedef enum logic [2:0] {S_SLA, S_REG, S_DATA, S_SLAR, S_RD} dscp_stg_e;

  dscp_hst_e st_reg;
  dscp_stg_e stg_reg;
  logic [7:0] tmr_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [3:0] left_reg;
  logic [6:0] addr_reg;
  logic rdop_reg;
  logic spi_reg;
  logic [1:0] sda_s_reg;

  wire sda_in = sda_s_reg[1];
  wire tick = tmr_reg == 8'h00;
  wire sym_end = tick & (ph_reg == 2'h3) & (st_reg != H_IDLE);
  wire [7:0] ph_len = (spi_reg ? SPI_PH : I2C_PH) - 8'h01;
  wire [3:0] last_bit = spi_reg ? 4'h7 : 4'h8;
  wire tx_bit = ((stg_reg != S_RD) && (bit_reg != 4'h8)) ? sh_reg[7] : 1'b1;
  wire in_bit = st_reg == H_BIT;
  // While idle the pins follow the requested mode at once, so the strap is settled
  // before the converter captures it just after reset release.
  wire spi_pin = (st_reg == H_IDLE) ? spi_mode_i : spi_reg;
  wire scl_nx = (st_reg == H_START) ? ((ph_reg == 2'h1) || (ph_reg == 2'h2)) :
                (st_reg == H_STOP) ? (ph_reg != 2'h0) :
                in_bit ? ph_reg[1] :
                (st_reg == H_IDLE) & ~spi_pin;
  wire sda_nx = (st_reg == H_START) ? ~ph_reg[1] :
                (st_reg == H_STOP) ? ph_reg[1] :
                in_bit ? tx_bit : 1'b1;
  wire sel_nx = spi_pin ? ~((st_reg == H_SELLO) | in_bit) : addr_sel_i[0];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_s_reg <= 2'h3;
      tmr_reg <= 8'h00;
      ph_reg <= 2'h0;
    end else begin
      sda_s_reg <= {sda_s_reg[0], link.ctl_serial_data_in};
      if (st_reg == H_IDLE || tick) begin
        tmr_reg <= ph_len;
      end else begin
        tmr_reg <= tmr_reg - 8'h01;
      end
      if (st_reg == H_IDLE) begin
        ph_reg <= 2'h0;
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link.mode_sel <= 1'b0;
      link.ctl_bit_clock <= 1'b1;
      link.ctl_port_select <= 1'b1;
      link.bus_addr_sel_hi <= 1'b0;
      link.host_dat_o <= 1'b0;
      link.host_dat_oe <= 1'b0;
    end else begin
      link.mode_sel <= spi_pin;
      link.ctl_bit_clock <= scl_nx;
      link.ctl_port_select <= sel_nx;
      link.bus_addr_sel_hi <= addr_sel_i[1];
      link.host_dat_o <= spi_pin & sda_nx;
      link.host_dat_oe <= spi_pin | ~sda_nx;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= H_IDLE;
      stg_reg <= S_REG;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      left_reg <= 4'h0;
      addr_reg <= 7'h00;
      rdop_reg <= 1'b0;
      spi_reg <= 1'b0;
      cmd_ready_o <= 1'b0;
      data_take_o <= 1'b0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      data_take_o <= 1'b0;
      done_o <= 1'b0;
      unique case (st_reg)
        H_IDLE: begin
          spi_reg <= spi_mode_i;
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            addr_reg <= cmd_addr_i;
            left_reg <= cmd_len_i;
            rdop_reg <= cmd_read_i & ~spi_mode_i;
            nack_o <= 1'b0;
            bit_reg <= 4'h0;
            stg_reg <= spi_mode_i ? S_REG : S_SLA;
            sh_reg <= {1'b0, cmd_addr_i};
            st_reg <= spi_mode_i ? H_SELLO : H_START;
          end
        end
        H_SELLO: begin
          if (sym_end) begin
            st_reg <= H_BIT;
          end
        end
        H_START: begin
          if (sym_end) begin
            st_reg <= H_BIT;
            bit_reg <= 4'h0;
            sh_reg <= {SLA_FIXED, addr_sel_i, stg_reg == S_SLAR};
          end
        end
        H_BIT: begin
          if (sym_end) begin
            if (bit_reg != last_bit) begin
              bit_reg <= bit_reg + 4'h1;
              sh_reg <= {sh_reg[6:0], sda_in};
            end else begin
              bit_reg <= 4'h0;
              if (!spi_reg && stg_reg != S_RD && sda_in) begin
                nack_o <= 1'b1;
                st_reg <= H_STOP;
              end else begin
                unique case (stg_reg)
                  S_SLA: begin
                    stg_reg <= S_REG;
                    sh_reg <= {1'b0, addr_reg};
                  end
                  S_REG: begin
                    if (rdop_reg) begin
                      stg_reg <= S_SLAR;
                      st_reg <= H_START;
                    end else begin
                      stg_reg <= S_DATA;
                      sh_reg <= cmd_data_i;
                      data_take_o <= 1'b1;
                    end
                  end
                  S_DATA: begin
                    if (left_reg != 4'h0) begin
                      left_reg <= left_reg - 4'h1;
                      sh_reg <= cmd_data_i;
                      data_take_o <= 1'b1;
                    end else begin
                      st_reg <= spi_reg ? H_SELHI : H_STOP;
                    end
                  end
                  S_SLAR: begin
                    stg_reg <= S_RD;
                  end
                  S_RD: begin
                    rd_data_o <= sh_reg;
                    st_reg <= H_STOP;
                  end
                  default: begin
                    st_reg <= H_STOP;
                  end
                endcase
              end
            end
          end
        end
        H_STOP, H_SELHI: begin
          if (sym_end) begin
            st_reg <= H_IDLE;
            done_o <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : dscp_host
`default_nettype wire

// File: hdl/dscp_link_if.sv
// Pins between the host and the converter's control port.
// The shared data pin has a pull-up: a pin that neither end drives reads one.
`timescale 1ns/100ps
`default_nettype none
interface dscp_link_if;
  logic mode_sel;
  logic ctl_bit_clock;
  logic ctl_port_select;
  logic bus_addr_sel_hi;
  logic host_dat_o;
  logic host_dat_oe;
  logic dev_dat_o;
  logic dev_dat_oe;
  logic ctl_serial_data_in;

  // Wired-AND with pull-up on the data pin.
  assign ctl_serial_data_in = (host_dat_oe ? host_dat_o : 1'b1) & (dev_dat_oe ? dev_dat_o : 1'b1);

  modport host_mp (
    output mode_sel,
    output ctl_bit_clock,
    output ctl_port_select,
    output bus_addr_sel_hi,
    output host_dat_o,
    output host_dat_oe,
    input ctl_serial_data_in
  );

  modport dev_mp (
    input mode_sel,
    input ctl_bit_clock,
    input ctl_port_select,
    input bus_addr_sel_hi,
    output dev_dat_o,
    output dev_dat_oe,
    input ctl_serial_data_in
  );
endinterface : dscp_link_if
`default_nettype wire

// File: hdl/dscp_pkg.sv
// Shared constants for both ends of the dual serial control port.
// Assumes a 100 MHz system clock on both ends.
package dscp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Three-wire word: the first unit is 16 bits, every further unit is 8 bits.
  localparam logic [4:0] SPI_FIRST_LAST = 5'h0F;
  localparam logic [4:0] SPI_BYTE_LAST = 5'h07;
  localparam logic [3:0] SPI_MAX_EXTRA = 4'hF;
  // Two-wire slave address upper bits and the defined register window.
  localparam logic [4:0] SLA_FIXED = 5'h13;
  localparam logic [6:0] REG_FIRST = 7'h40;
  localparam logic [6:0] REG_LAST = 7'h4F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // Cycles after reset release before the mode strap is captured.
  localparam logic [1:0] MODE_SETTLE = 2'h3;
  // Host link timing: one bit is four phases, clock low for two, high for two.
  localparam int SPI_PH_NS = 50;
  localparam int SPI_PH_CYC = (SPI_PH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int I2C_PH_NS = 650;
  localparam int I2C_PH_CYC = (I2C_PH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dscp_pkg

// File: verification/dscp_link_chk.sv
// Checker on the link pins between the host and converter ends of the control port.
// Assumes one clock for both ends and a shared active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module dscp_link_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mode_sel,
  input wire logic ctl_bit_clock,
  input wire logic ctl_port_select,
  input wire logic bus_addr_sel_hi,
  input wire logic host_dat_o,
  input wire logic host_dat_oe,
  input wire logic dev_dat_o,
  input wire logic dev_dat_oe,
  input wire logic ctl_serial_data_in
);
  logic [2:0] settle_reg;
  logic mc_reg;
  logic [7:0] rise_reg;
  wire logic mc_rise = ctl_bit_clock & ~mc_reg;
  // Counts bit clock rises while the three-wire port is selected.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settle_reg <= 3'h0;
      mc_reg <= 1'b1;
      rise_reg <= 8'h00;
    end else begin
      settle_reg <= settle_reg + {2'h0, settle_reg != 3'h7};
      mc_reg <= ctl_bit_clock;
      rise_reg <= ctl_port_select ? 8'h00 : rise_reg + {7'h00, mc_rise};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_sel_fall;
    mode_sel && $fell(ctl_port_select);
  endsequence
  sequence s_dev_edge;
    !mode_sel && $changed(dev_dat_oe);
  endsequence
  property p_sel_setup;
    s_sel_fall |-> !ctl_bit_clock [*3];
  endproperty
  property p_dev_edge;
    s_dev_edge |-> !ctl_bit_clock;
  endproperty
  property p_dev_pull_low;
    dev_dat_oe |-> !dev_dat_o;
  endproperty
  property p_host_pull_low;
    !mode_sel && host_dat_oe |-> !host_dat_o;
  endproperty
  property p_dev_quiet;
    mode_sel && $past(mode_sel) |-> !dev_dat_oe;
  endproperty
  property p_mc_selected;
    mode_sel && mc_rise |-> !ctl_port_select;
  endproperty
  property p_one_driver;
    !mode_sel && ctl_bit_clock && dev_dat_oe |-> !host_dat_oe;
  endproperty
  property p_data_stable;
    mode_sel && ctl_bit_clock && $past(ctl_bit_clock) |-> $stable(ctl_serial_data_in);
  endproperty
  property p_straps_stable;
    settle_reg >= 3'h2 |-> $stable(mode_sel) && $stable(bus_addr_sel_hi);
  endproperty
  property p_word_count;
    mode_sel && $rose(ctl_port_select) |->
      rise_reg >= 8'h10 && rise_reg <= 8'h88 && rise_reg[2:0] == 3'h0;
  endproperty
  a_sel_setup: assert property (p_sel_setup) else $error("early bit clock");
  a_dev_edge: assert property (p_dev_edge) else $error("data moved in high");
  a_dev_pull_low: assert property (p_dev_pull_low) else $error("device drove high");
  a_host_pull_low: assert property (p_host_pull_low) else $error("host drove high");
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drove in 3-wire");
  a_mc_selected: assert property (p_mc_selected) else $error("clock while idle");
  a_one_driver: assert property (p_one_driver) else $error("both ends drive");
  a_data_stable: assert property (p_data_stable) else $error("data moved in high");
  a_straps_stable: assert property (p_straps_stable) else $error("strap moved");
  a_word_count: assert property (p_word_count) else $error("bad pulse count");
endmodule : dscp_link_chk
`default_nettype wire

// File: verification/dual_serial_control_port_test.sv
// Bench joining the host and converter ends over the link interface.
// Assumes both ends share one 100 MHz clock; the register file is modelled here.
`timescale 1ns/100ps
`default_nettype none
module dual_serial_control_port_test;
  import dscp_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic spi_mode = 1'b1;
  logic [1:0] addr_sel = 2'h0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [3:0] cmd_len = 4'h0;
  logic cmd_ready, data_take, done, nack, dev_wr, dev_mode, mode_valid;
  logic [7:0] rd_byte, wr_data, sh;
  logic [6:0] wr_addr, rd_addr;
  logic [7:0] regs [128];
  logic [7:0] shadow [128];
  logic [7:0] dq [16];
  logic [14:0] got_q [$];
  logic [14:0] exp_q [$];
  int k = 0;
  int nb = 8;
  int num_errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'hCB822BE4;
  wire logic [7:0] cmd_data = dq[k[3:0]];
  wire logic [7:0] rd_data = regs[rd_addr];
  dscp_link_if dscp_link_if_i ();
  wire logic scl = dscp_link_if_i.ctl_bit_clock;
  wire logic sda = dscp_link_if_i.ctl_serial_data_in;
  wire logic sel = dscp_link_if_i.ctl_port_select;
  dscp_host #(.I2C_PH(8'h08)) dscp_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .link(dscp_link_if_i.host_mp), .spi_mode_i(spi_mode), .addr_sel_i(addr_sel),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
    .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .cmd_data_i(cmd_data),
    .data_take_o(data_take), .done_o(done), .nack_o(nack), .rd_data_o(rd_byte));
  dscp_device dscp_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .link(dscp_link_if_i.dev_mp), .wr_o(dev_wr), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data), .spi_mode_o(dev_mode),
    .mode_valid_o(mode_valid));
  dscp_link_chk dscp_link_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .mode_sel(dscp_link_if_i.mode_sel), .ctl_bit_clock(scl), .ctl_port_select(sel),
    .bus_addr_sel_hi(dscp_link_if_i.bus_addr_sel_hi), .host_dat_o(dscp_link_if_i.host_dat_o),
    .host_dat_oe(dscp_link_if_i.host_dat_oe), .dev_dat_o(dscp_link_if_i.dev_dat_o),
    .dev_dat_oe(dscp_link_if_i.dev_dat_oe), .ctl_serial_data_in(sda));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [6:0] nxt(input logic [6:0] a);
    return (!spi_mode && a == REG_LAST) ? REG_FIRST : a + 7'h01;
  endfunction : nxt
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic mode, input logic [1:0] s);
    sys_rst_i = 1'b1;
    spi_mode = mode;
    addr_sel = s;
    repeat (4) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    check("mode valid", mode_valid, 1'b1);
    check("mode", dev_mode, mode);
  endtask : do_reset
  task automatic run(input string name, input logic rd, input logic [6:0] a, input logic [3:0] n);
    int t;
    logic [6:0] ea;
    logic bad;
    ea = a;
    bad = !spi_mode && (a < REG_FIRST || a > REG_LAST);
    for (int i = 0; i < 16; i++) dq[i] = 8'(rnd());
    for (int i = 0; i <= n; i++) begin
      if (!rd && !bad) begin
        exp_q.push_back({ea, dq[i]});
        shadow[ea] = dq[i];
        ea = nxt(ea);
      end
    end
    k = 0;
    check("ready", cmd_ready, 1'b1);
    cmd_read = rd;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    @(posedge clk_i);
    #1 cmd_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 20000) begin
      @(posedge clk_i);
      #1 t++;
    end
    check("done", done, 1'b1);
    repeat (8) @(posedge clk_i);
    #1;
    check("write count", got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0) check("write", got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
    if (!spi_mode) check("nack", nack, bad);
    if (rd) check("read byte", rd_byte, shadow[a]);
    if (!spi_mode && !bad) check("index", rd_addr, rd ? a : ea);
    $display("test %s done", name);
  endtask : run
  always @(posedge clk_i) if (data_take === 1'b1) k <= k + 1;
  always @(posedge clk_i) begin
    if (dev_wr === 1'b1) begin
      regs[wr_addr] <= wr_data;
      got_q.push_back({wr_addr, wr_data});
    end
  end
  // Watches the first byte after every start condition and the first word bit.
  always @(posedge scl) begin
    if (spi_mode && nb == 0) check("write bit", sda, 1'b0);
    sh = {sh[6:0], sda};
    nb++;
    if (!spi_mode && nb == 8) check("slave address", sh[7:1], {SLA_FIXED, addr_sel});
  end
  always @(negedge sda) if (scl === 1'b1 && !spi_mode) nb = 0;
  always @(negedge sel) if (spi_mode) nb = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    check("watchdog", 1'b0, 1'b1);
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'h00;
      shadow[i] = 8'h00;
      dq[i[3:0]] = 8'h00;
    end
    do_reset(1'b1, 2'h0);
    run("spi single", 1'b0, 7'(rnd()), 4'h0);
    run("spi longest burst", 1'b0, 7'h40, 4'hF);
    repeat (3) run("spi burst", 1'b0, 7'(rnd() & 32'h3F), 4'(rnd()));
    for (int s = 0; s < 4; s++) begin
      do_reset(1'b0, 2'(s));
      run("bus write", 1'b0, REG_FIRST | 7'(rnd() & 32'hF), 4'(rnd()));
    end
    run("bus wrap", 1'b0, 7'h4E, 4'h3);
    run("bus read", 1'b1, 7'h4F, 4'h0);
    run("bus undefined low", 1'b0, 7'h3F, 4'h0);
    run("bus undefined high", 1'b0, 7'h50, 4'h2);
    run("bus read again", 1'b1, 7'h41, 4'h0);
    give_verdict();
  end
endmodule : dual_serial_control_port_test
`default_nettype wire
